// ### verilog/axrf_pkg.sv
// axrf_pkg: constants and carriers for the AXI region access filter
// assumes 32-bit AXI addresses, 8-bit IDs, 32-bit data, 4 KB address pages
`default_nettype none
package axrf_pkg;
   localparam int ADDR_W = 32;
   localparam int ID_W   = 8;
   localparam int DATA_W = 32;
   localparam int PAGE_W = 20;                         // address bits above 4 KB
   localparam int NREG   = 16;
   localparam logic [19:0] PAGE_MASK_1MB = 20'hFFF00;  // drop page bits below 1 MB
   localparam logic [19:0] PAGE_MASK_4KB = 20'hFFFFF;
   // configuration offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_LOCK   = 12'h004;
   localparam logic [11:0] OFS_POISON = 12'h008;
   localparam logic [3:0]  OFS_REGION = 4'h1;         // cfgAddr[11:8], region n at 0x100 + 0x10*n
   localparam logic [3:0]  OFS_START  = 4'h0;
   localparam logic [3:0]  OFS_END    = 4'h4;
   localparam logic [3:0]  OFS_ATTR   = 4'h8;
   // control word, bits [3:0]
   typedef struct packed {
      logic irqEn;
      logic granule4k;
      logic poisonByAddr;
      logic defaultAllow;
   } axrf_ctrl_t;
   localparam axrf_ctrl_t  CTRL_RST   = 4'h0;
   localparam logic [31:0] POISON_RST = 32'h0000_0000;
   // region attribute word, bits [19:0]
   typedef struct packed {
      logic [ID_W-1:0] idMask;
      logic [ID_W-1:0] id;
      logic            wrAllow;
      logic            rdAllow;
      logic            secureOnly;
      logic            enable;
   } axrf_attr_t;
   typedef struct packed {
      logic [PAGE_W-1:0] startPage;
      logic [PAGE_W-1:0] endPage;
      axrf_attr_t        attr;
   } axrf_region_t;
   // AXI channel payloads; prot[1] high marks a non-secure request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [ID_W-1:0]   id;
      logic [7:0]        len;
      logic [2:0]        size;
      logic [1:0]        burst;
      logic [2:0]        prot;
   } axrf_ax_t;
   typedef struct packed {
      logic [DATA_W-1:0]   data;
      logic [DATA_W/8-1:0] strb;
      logic                last;
   } axrf_w_t;
   typedef struct packed {
      logic [ID_W-1:0]   id;
      logic [DATA_W-1:0] data;
      logic [1:0]        resp;
      logic              last;
   } axrf_r_t;
   typedef struct packed {
      logic [ID_W-1:0] id;
      logic [1:0]      resp;
   } axrf_b_t;
endpackage
`default_nettype wire

// ### verilog/axrf_region_match.sv
// axrf_region_match: one region checked against one request, purely combinational
// assumes the region word is stable while the request is presented
`default_nettype none
module axrf_region_match (
   input  wire  axrf_pkg::axrf_region_t        region,
   input  wire  logic [axrf_pkg::PAGE_W-1:0]   page,
   input  wire  logic [axrf_pkg::ID_W-1:0]     id,
   input  wire  logic                          secure,
   input  wire  logic                          isWrite,
   input  wire  logic                          granule4k,
   output logic                                hit,
   output logic                                secFail,
   output logic                                permFail
);
   logic [axrf_pkg::PAGE_W-1:0] mask;
   logic                        addrIn;
   logic                        idOk;

   assign mask   = granule4k ? axrf_pkg::PAGE_MASK_4KB : axrf_pkg::PAGE_MASK_1MB;
   assign addrIn = ((page & mask) >= (region.startPage & mask)) && ((page & mask) <= (region.endPage & mask));
   assign idOk   = ((id ^ region.attr.id) & region.attr.idMask) == '0;
   assign hit    = region.attr.enable & addrIn & idOk;
   assign secFail  = region.attr.secureOnly & ~secure;
   assign permFail = isWrite ? ~region.attr.wrAllow : ~region.attr.rdAllow;
endmodule
`default_nettype wire

// ### verilog/axrf_chan_slice.sv
// axrf_chan_slice: one-entry register slice for an address channel plus poison bit
// assumes standard valid/ready: data held while valid and not ready
`default_nettype none
module axrf_chan_slice #(
   parameter int W = 1
) (
   input  wire  logic         sys_clk,
   input  wire  logic         reset_n,
   input  wire  logic         inValid,
   output logic               inReady,
   input  wire  logic [W-1:0] inData,
   input  wire  logic         inPoison,
   output logic               outValid,
   input  wire  logic         outReady,
   output logic [W-1:0]       outData,
   output logic               outPoison
);
   typedef struct packed {
      logic         valid;
      logic         poison;
      logic [W-1:0] data;
   } axrf_slice_t;
   axrf_slice_t s_q;
   axrf_slice_t s_d;

   // empty or draining this cycle, so a new word may enter
   assign inReady   = ~s_q.valid | outReady;
   assign outValid  = s_q.valid;
   assign outData   = s_q.data;
   assign outPoison = s_q.poison;

   // next entry
   always_comb begin
      s_d = s_q;
      if (outReady) s_d.valid = 1'b0;
      if (inValid && inReady) begin
         s_d.valid  = 1'b1;
         s_d.poison = inPoison;
         s_d.data   = inData;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) s_q <= '0;
      else s_q <= s_d;
   end
endmodule
`default_nettype wire

// ### verilog/axrf_filter.sv
// axrf_filter: inline AXI region access filter with plain configuration ports
// assumes one clock for both AXI sides and the configuration port; inputs synchronous

`default_nettype none
module axrf_filter (
   input  wire  logic                          sys_clk,
   input  wire  logic                          reset_n,
   input  wire  axrf_pkg::axrf_ax_t            sAw,
   input  wire  logic                          sAwValid,
   output logic                                sAwReady,
   output axrf_pkg::axrf_ax_t                  mAw,
   output logic                                mAwValid,
   input  wire  logic                          mAwReady,
   output logic                                mAwPoison,
   input  wire  axrf_pkg::axrf_ax_t            sAr,
   input  wire  logic                          sArValid,
   output logic                                sArReady,
   output axrf_pkg::axrf_ax_t                  mAr,
   output logic                                mArValid,
   input  wire  logic                          mArReady,
   output logic                                mArPoison,
   input  wire  axrf_pkg::axrf_w_t             sW,
   input  wire  logic                          sWValid,
   output logic                                sWReady,
   output axrf_pkg::axrf_w_t                   mW,
   output logic                                mWValid,
   input  wire  logic                          mWReady,
   input  wire  axrf_pkg::axrf_r_t             mR,
   input  wire  logic                          mRValid,
   output logic                                mRReady,
   output axrf_pkg::axrf_r_t                   sR,
   output logic                                sRValid,
   input  wire  logic                          sRReady,
   input  wire  axrf_pkg::axrf_b_t             mB,
   input  wire  logic                          mBValid,
   output logic                                mBReady,
   output axrf_pkg::axrf_b_t                   sB,
   output logic                                sBValid,
   input  wire  logic                          sBReady,
   input  wire  logic                          cfgWrite,
   input  wire  logic                          cfgSecure,
   input  wire  logic [11:0]                   cfgAddr,
   input  wire  logic [31:0]                   cfgWdata,
   input  wire  logic                          errClear,
   output logic                                cfgLocked,
   output logic                                violFlag,
   output logic                                violSecurity,
   output logic                                violWrite,
   output logic [axrf_pkg::ADDR_W-1:0]         violAddr,
   output logic [axrf_pkg::ID_W-1:0]           violId,
   output logic                                violIrq
);
   typedef struct packed {
      axrf_pkg::axrf_ctrl_t                        ctrl;
      logic                                        lock;
      logic [axrf_pkg::ADDR_W-1:0]                 poisonAddr;
      axrf_pkg::axrf_region_t [axrf_pkg::NREG-1:0] region;
      logic                                        flag;
      logic                                        sec;
      logic                                        wr;
      logic [axrf_pkg::ADDR_W-1:0]                 addr;
      logic [axrf_pkg::ID_W-1:0]                   id;
   } axrf_state_t;
   // the configuration and log state live in one record, so reset covers it together; lock freezes only the configuration fields
   localparam axrf_state_t ST_RST = '{ctrl: axrf_pkg::CTRL_RST, poisonAddr: axrf_pkg::POISON_RST, default: '0};

   axrf_state_t                 s_q;
   axrf_state_t                 s_d;
   // channel 0 is read, channel 1 is write
   logic [axrf_pkg::PAGE_W-1:0] reqPage [2];
   logic [axrf_pkg::ID_W-1:0]   reqId   [2];
   logic                        reqSec  [2];
   logic [axrf_pkg::NREG-1:0]   hitV    [2];
   logic [axrf_pkg::NREG-1:0]   secF    [2];
   logic [axrf_pkg::NREG-1:0]   permF   [2];
   logic                        anyHit  [2];
   logic                        selSec  [2];
   logic                        selPerm [2];
   logic                        chFail  [2];
   logic                        chSecF  [2];
   logic                        arFire;
   logic                        awFire;
   axrf_pkg::axrf_ax_t          arOut;
   logic                        arPoisonIn;
   logic                        cfgOk;
   logic                        held;
   logic [3:0]                  regIdx;

   // request fields seen by the checkers
   assign reqPage[0] = sAr.addr[axrf_pkg::ADDR_W-1 -: axrf_pkg::PAGE_W];
   assign reqPage[1] = sAw.addr[axrf_pkg::ADDR_W-1 -: axrf_pkg::PAGE_W];
   assign reqId[0]   = sAr.id;
   assign reqId[1]   = sAw.id;
   assign reqSec[0]  = ~sAr.prot[1];
   assign reqSec[1]  = ~sAw.prot[1];

   // every region against both channels
   // thirty-two small comparators: area is traded for a decision in the accept cycle
   for (genvar c = 0; c < 2; c++) begin : g_ch
      for (genvar r = 0; r < axrf_pkg::NREG; r++) begin : g_rg
         axrf_region_match u_match (
            .region    (s_q.region[r]),
            .page      (reqPage[c]),
            .id        (reqId[c]),
            .secure    (reqSec[c]),
            .isWrite   (c == 1),
            .granule4k (s_q.ctrl.granule4k),
            .hit       (hitV[c][r]),
            .secFail   (secF[c][r]),
            .permFail  (permF[c][r])
         );
      end
   end

   // later index overrides, so the highest hit decides
   // a linear scan is cheap at sixteen regions and keeps the priority obvious
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         anyHit[c]  = 1'b0;
         selSec[c]  = 1'b0;
         selPerm[c] = 1'b0;
         for (int r = 0; r < axrf_pkg::NREG; r++) begin
            if (hitV[c][r]) begin
               anyHit[c]  = 1'b1;
               selSec[c]  = secF[c][r];
               selPerm[c] = permF[c][r];
            end
         end
         chFail[c] = anyHit[c] ? (selSec[c] | selPerm[c]) : ~s_q.ctrl.defaultAllow;
         // security kind only from a real hit
         chSecF[c] = anyHit[c] & selSec[c];
      end
   end

   assign arFire = sArValid & sArReady;
   assign awFire = sAwValid & sAwReady;

   // reads can be steered to the decoy instead of poisoned
   // limitation: the slave sees only the decoy address, so it cannot log the original one
   always_comb begin
      arOut      = sAr;
      arPoisonIn = chFail[0];
      if (chFail[0] && s_q.ctrl.poisonByAddr) begin
         arOut.addr = s_q.poisonAddr;
         arPoisonIn = 1'b0;
      end
   end

   // one slice per address channel: a cycle of latency buys a registered poison bit
   // the slice refills as it drains, so back-to-back requests keep full throughput
   // writes always use the poison bit, a redirected write would still land
   axrf_chan_slice #(.W($bits(axrf_pkg::axrf_ax_t))) u_aw (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .inValid   (sAwValid),
      .inReady   (sAwReady),
      .inData    (sAw),
      .inPoison  (chFail[1]),
      .outValid  (mAwValid),
      .outReady  (mAwReady),
      .outData   (mAw),
      .outPoison (mAwPoison)
   );

   axrf_chan_slice #(.W($bits(axrf_pkg::axrf_ax_t))) u_ar (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .inValid   (sArValid),
      .inReady   (sArReady),
      .inData    (arOut),
      .inPoison  (arPoisonIn),
      .outValid  (mArValid),
      .outReady  (mArReady),
      .outData   (mAr),
      .outPoison (mArPoison)
   );

   // data and response channels pass straight through
   // nothing is filtered here: a poisoned write still sends its data and the slave drops it
   assign mW      = sW;
   assign mWValid = sWValid;
   assign sWReady = mWReady;
   assign sR      = mR;
   assign sRValid = mRValid;
   assign mRReady = sRReady;
   assign sB      = mB;
   assign sBValid = mBValid;
   assign mBReady = sBReady;

   // only secure writers reach the registers
   assign cfgOk  = cfgWrite & cfgSecure & ~s_q.lock;
   assign regIdx = cfgAddr[7:4];
   // log held until cleared
   // a clear in the cycle of a new failure re-arms the log, so that failure is kept
   assign held   = s_q.flag & ~errClear;

   // configuration writes and violation log
   always_comb begin
      s_d = s_q;
      // no configuration field changes once locked; the violation log still updates
      // unmapped offsets fall through every branch and are ignored
      if (cfgOk) begin
         if (cfgAddr == axrf_pkg::OFS_CTRL) s_d.ctrl = cfgWdata[3:0];
         else if (cfgAddr == axrf_pkg::OFS_LOCK) s_d.lock = cfgWdata[0];
         else if (cfgAddr == axrf_pkg::OFS_POISON) s_d.poisonAddr = cfgWdata;
         else if (cfgAddr[11:8] == axrf_pkg::OFS_REGION) begin
            if (cfgAddr[3:0] == axrf_pkg::OFS_START) s_d.region[regIdx].startPage = cfgWdata[31:12];
            else if (cfgAddr[3:0] == axrf_pkg::OFS_END) s_d.region[regIdx].endPage = cfgWdata[31:12];
            else if (cfgAddr[3:0] == axrf_pkg::OFS_ATTR) s_d.region[regIdx].attr = cfgWdata[19:0];
         end
      end
      if (errClear) s_d.flag = 1'b0;
      // first failure only, read wins a tie; a new failure beats the clear
      if (!held && arFire && chFail[0]) begin
         s_d.flag = 1'b1;
         s_d.sec  = chSecF[0];
         s_d.wr   = 1'b0;
         s_d.addr = sAr.addr;
         s_d.id   = sAr.id;
      end else if (!held && awFire && chFail[1]) begin
         s_d.flag = 1'b1;
         s_d.sec  = chSecF[1];
         s_d.wr   = 1'b1;
         s_d.addr = sAw.addr;
         s_d.id   = sAw.id;
      end
   end

   // single shared clock for both AXI sides
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) s_q <= ST_RST;
      else s_q <= s_d;
   end

   // log outputs come straight from flops; violIrq is the flag flop ANDed with the irqEn flop
   assign cfgLocked    = s_q.lock;
   assign violFlag     = s_q.flag;
   assign violSecurity = s_q.sec;
   assign violWrite    = s_q.wr;
   assign violAddr     = s_q.addr;
   assign violId       = s_q.id;
   assign violIrq      = s_q.flag & s_q.ctrl.irqEn;

   // checks on the filter's own behaviour
   // all of them sample on the shared clock and sleep while reset is low
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // configuration guard
   AST_LOCK_STICKY: assert property (s_q.lock |=> s_q.lock)
      else $error("lock cleared without reset");

   AST_LOCK_FREEZE: assert property (s_q.lock |=> ($stable(s_q.ctrl) && $stable(s_q.region)
                                                   && $stable(s_q.poisonAddr)))
      else $error("configuration changed while locked");

   AST_NONSEC_CFG: assert property ((cfgWrite && !cfgSecure) |=> ($stable(s_q.ctrl) && $stable(s_q.lock)
                                                                 && $stable(s_q.region)))
      else $error("non-secure write altered configuration");

   // region decision
   AST_MISS_DEFAULT: assert property ((arFire && hitV[0] == '0 && !s_q.ctrl.defaultAllow
                                       && !s_q.ctrl.poisonByAddr) |=> mArPoison)
      else $error("miss not poisoned under deny default");

   AST_TOP_REGION: assert property ((arFire && hitV[0][axrf_pkg::NREG-1])
                                    |-> chFail[0] == (secF[0][axrf_pkg::NREG-1] | permF[0][axrf_pkg::NREG-1]))
      else $error("highest region did not decide");

   // forwarding on the master side
   AST_PASS: assert property ((arFire && !chFail[0]) |=> (mArValid && !mArPoison && mAr == $past(sAr)))
      else $error("allowed read not forwarded unchanged");

   AST_AW_PASS: assert property ((awFire && !chFail[1]) |=> (mAwValid && !mAwPoison && mAw == $past(sAw)))
      else $error("allowed write not forwarded unchanged");

   AST_REDIRECT: assert property ((arFire && chFail[0] && s_q.ctrl.poisonByAddr)
                                  |=> (mAr.addr == $past(s_q.poisonAddr) && !mArPoison))
      else $error("refused read not redirected");

   AST_AW_POISON: assert property ((awFire && chFail[1]) |=> (mAwValid && mAwPoison))
      else $error("refused write not poisoned");

   AST_AR_STALL: assert property ((mArValid && !mArReady) |=> (mArValid && $stable(mAr)))
      else $error("read request dropped under stall");

   AST_AW_STALL: assert property ((mAwValid && !mAwReady) |=> (mAwValid && $stable(mAw) && $stable(mAwPoison)))
      else $error("write request dropped under stall");

   // violation log and interrupt
   AST_CAPTURE: assert property ((arFire && chFail[0] && !s_q.flag)
                                 |=> (violFlag && !violWrite && violAddr == $past(sAr.addr)))
      else $error("first read failure not logged");

   AST_WR_CAPTURE: assert property ((awFire && chFail[1] && !s_q.flag && !(arFire && chFail[0]))
                                    |=> (violFlag && violWrite && violId == $past(sAw.id)))
      else $error("first write failure not logged");

   AST_SEC_KIND: assert property ((awFire && chSecF[1] && !s_q.flag && !(arFire && chFail[0]))
                                  |=> (violSecurity && violWrite))
      else $error("security failure not marked");

   AST_HOLD: assert property ((s_q.flag && !errClear) |=> ($stable(violAddr) && $stable(violId) && violFlag))
      else $error("log changed before clear");

   AST_CLEAR: assert property ((errClear && !(arFire && chFail[0]) && !(awFire && chFail[1]))
                               |=> !violFlag)
      else $error("violation flag not cleared");

   AST_IRQ: assert property ((violIrq && !errClear && !cfgOk) |=> violIrq)
      else $error("interrupt dropped while pending");

   // scenarios worth seeing at least once
   COV_REDIRECT: cover property (arFire && chFail[0] && s_q.ctrl.poisonByAddr);
   COV_WR_POISON: cover property (awFire && chFail[1] ##1 mAwPoison);
   COV_SEC_LOG: cover property (arFire && chSecF[0] && !s_q.flag ##1 violSecurity);
   COV_LOCKED: cover property (s_q.lock && cfgWrite && cfgSecure);
endmodule
`default_nettype wire

// ### verif/axrf_mem_model.sv
// axrf_mem_model: protected slave behind the filter, with random stalls
// assumes single-beat requests; responses leave in the order they arrived
`default_nettype none
module axrf_mem_model (
   input  wire  logic               sys_clk,
   input  wire  logic               reset_n,
   input  wire  axrf_pkg::axrf_ax_t mAr,
   input  wire  logic               mArValid,
   output logic                     mArReady,
   input  wire  logic               mArPoison,
   input  wire  axrf_pkg::axrf_ax_t mAw,
   input  wire  logic               mAwValid,
   output logic                     mAwReady,
   output logic                     mWReady,
   output axrf_pkg::axrf_r_t        mR,
   output logic                     mRValid,
   input  wire  logic               mRReady,
   output axrf_pkg::axrf_b_t        mB,
   output logic                     mBValid,
   input  wire  logic               mBReady
);
   timeunit 1ns;
   timeprecision 1ps;
   integer            seed = 59846;
   axrf_pkg::axrf_r_t rq[$];
   axrf_pkg::axrf_b_t bq[$];
   // no write storage, so poisoned writes vanish here anyway
   assign mWReady = 1'b1;
   // ready stalls at random; idle payloads keep toggling so stale data never looks valid
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {mArReady, mAwReady, mRValid, mBValid} <= 4'h0;
         mR <= '0;
         mB <= '0;
      end else begin
         mArReady <= ($random(seed) & 3) != 0;
         mAwReady <= ($random(seed) & 3) != 0;
         if (mArValid && mArReady) rq.push_back('{mAr.id, mArPoison ? 32'h0 : mAr.addr, 2'h0, 1'b1});
         if (mAwValid && mAwReady) bq.push_back('{mAw.id, 2'h0});
         if (mRValid && mRReady) mRValid <= 1'b0;
         else if (!mRValid && rq.size() > 0) begin
            mR <= rq.pop_front();
            mRValid <= 1'b1;
         end else if (!mRValid) mR.data <= ~mR.data;
         if (mBValid && mBReady) mBValid <= 1'b0;
         else if (!mBValid && bq.size() > 0) begin
            mB <= bq.pop_front();
            mBValid <= 1'b1;
         end else if (!mBValid) mB.id <= ~mB.id;
      end
   end
endmodule
`default_nettype wire

// ### verif/axrf_filter_bench.sv
// axrf_filter_bench: self-checking bench for the region access filter
// assumes axrf_mem_model as the protected slave and one 100 MHz clock
`default_nettype none
module axrf_filter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset_n, sAwValid, sAwReady, mAwValid, mAwReady, mAwPoison, sArValid, sArReady, mArValid;
   logic mArReady, mArPoison, sWValid, sWReady, mWValid, mWReady, mRValid, mRReady, sRValid, sRReady;
   logic mBValid, mBReady, sBValid, sBReady, cfgWrite, cfgSecure, errClear, cfgLocked, violFlag;
   logic violSecurity, violWrite, violIrq, locked;
   axrf_pkg::axrf_ax_t   sAw, mAw, sAr, mAr;
   axrf_pkg::axrf_w_t    sW, mW;
   axrf_pkg::axrf_r_t    mR, sR;
   axrf_pkg::axrf_b_t    mB, sB;
   axrf_pkg::axrf_ctrl_t ctrl;
   axrf_pkg::axrf_attr_t rA[16];
   logic [11:0]          cfgAddr;
   logic [31:0]          cfgWdata, violAddr, pAddr;
   logic [7:0]           violId;
   logic [19:0]          rS[16], rE[16];
   logic [56:0]          qAr[$], qAw[$];
   logic [39:0]          qR[$];
   integer               seed = 59846;
   int                   n_mismatch, samples_checked;
   axrf_filter uut (.*);
   axrf_mem_model slave (.*);
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // secure or non-secure writes; the bench model follows accepted writes alone
   task automatic cfg(logic [11:0] a, logic [31:0] d, logic sec);
      @(posedge sys_clk);
      {cfgWrite, cfgAddr, cfgWdata, cfgSecure} <= {1'b1, a, d, sec};
      if (sec && !locked) begin
         if (a == axrf_pkg::OFS_CTRL) ctrl = d[3:0];
         if (a == axrf_pkg::OFS_LOCK) locked = d[0];
         if (a == axrf_pkg::OFS_POISON) pAddr = d;
         if (a[11:8] == axrf_pkg::OFS_REGION && a[3:0] == axrf_pkg::OFS_START) rS[a[7:4]] = d[31:12];
         if (a[11:8] == axrf_pkg::OFS_REGION && a[3:0] == axrf_pkg::OFS_END) rE[a[7:4]] = d[31:12];
         if (a[11:8] == axrf_pkg::OFS_REGION && a[3:0] == axrf_pkg::OFS_ATTR) rA[a[7:4]] = d[19:0];
      end
      @(posedge sys_clk);
      cfgWrite <= 1'b0;
   endtask
   task automatic rg(logic [3:0] i, logic [31:0] s, logic [31:0] e, logic [19:0] at);
      cfg({4'h1, i, 4'h0}, s, 1'b1);
      cfg({4'h1, i, 4'h4}, e, 1'b1);
      cfg({4'h1, i, 4'h8}, {12'h0, at}, 1'b1);
   endtask
   // returns {security fail, fail, forwarded request, poison}
   function automatic logic [58:0] judge(axrf_pkg::axrf_ax_t x, logic wr);
      logic [19:0] m;
      logic        sec, fail;
      m = ctrl.granule4k ? axrf_pkg::PAGE_MASK_4KB : axrf_pkg::PAGE_MASK_1MB;
      sec = 1'b0;
      fail = !ctrl.defaultAllow;
      for (int i = 0; i < 16; i++)
         if (rA[i].enable && (rS[i] & m) <= (x.addr[31:12] & m) && (x.addr[31:12] & m) <= (rE[i] & m)
             && ((x.id ^ rA[i].id) & rA[i].idMask) == 8'h00) begin
            sec = rA[i].secureOnly && x.prot[1];
            fail = sec || !(wr ? rA[i].wrAllow : rA[i].rdAllow);
         end
      // refused reads go to the decoy when poisonByAddr is set
      if (fail && !wr && ctrl.poisonByAddr) x.addr = pAddr;
      return {sec, fail, x, fail && !(ctrl.poisonByAddr && !wr)};
   endfunction
   // valid is left up so requests can follow back to back
   task automatic req(logic wr, axrf_pkg::axrf_ax_t x);
      logic [58:0] e;
      e = judge(x, wr);
      if (wr) qAw.push_back(e[56:0]);
      else qAr.push_back(e[56:0]);
      if (!wr) qR.push_back({x.id, e[0] ? 32'h0 : e[56:25]});
      {sAw, sAr, sAwValid, sArValid} <= {x, x, wr, !wr};
      {sW, sWValid} <= {37'({$random(seed), $random(seed)}), wr};
      @(posedge sys_clk);
      while ((wr ? sAwReady : sArReady) !== 1'b1) @(posedge sys_clk);
   endtask
   task automatic idle;
      {sAwValid, sArValid} <= 2'b00;
      @(posedge sys_clk);
   endtask
   task automatic burst(int n);
      axrf_pkg::axrf_ax_t x;
      repeat (n) begin
         x = 56'({$random(seed), $random(seed)});
         if (x.addr[0]) x.addr[31:20] = 12'h100;
         if (x.addr[1]) x.addr[19:12] = {5'h10, x.addr[4:2]};
         if (x.id[7]) x.id = x.id[6] ? 8'h12 : {4'h3, x.id[3:0]};
         req(x.len[0], x);
      end
      idle();
   endtask
   task automatic clr;
      @(posedge sys_clk);
      errClear <= 1'b1;
      @(posedge sys_clk);
      errClear <= 1'b0;
      @(posedge sys_clk);
      chk("clear", violFlag, 1'b0);
   endtask
   // forwarded requests and returned read data, oldest note first
   always @(posedge sys_clk) begin
      if (mArValid === 1'b1 && mArReady === 1'b1) chk("ar", {mAr, mArPoison}, qAr.pop_front());
      if (mAwValid === 1'b1 && mAwReady === 1'b1) chk("aw", {mAw, mAwPoison}, qAw.pop_front());
      if (sRValid === 1'b1 && sRReady === 1'b1) chk("r", {sR.id, sR.data}, qR.pop_front());
      chk("pass", {mW, mWValid, sWReady, sB, sBValid, mRReady, mBReady},
          {sW, sWValid, mWReady, mB, mBValid, sRReady, sBReady});
   end
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // overall run is under a thousand cycles; this allows 40000 cycles
   initial begin
      #400000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      {reset_n, sAwValid, sArValid, sWValid, cfgWrite, cfgSecure, errClear, locked} = '0;
      {sAw, sAr, sW, cfgAddr, cfgWdata, pAddr} = '0;
      {sRReady, sBReady} = 2'b11;
      ctrl = axrf_pkg::CTRL_RST;
      foreach (rA[i]) {rA[i], rS[i], rE[i]} = '0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      req(1'b0, '{32'hA000_1234, 8'h5A, 8'h0, 3'h2, 2'h1, 3'h2});
      idle();
      chk("log", {cfgLocked, violFlag, violSecurity, violWrite, violIrq, violId, violAddr}, 45'h08_5AA000_1234);
      req(1'b1, '{32'hB000_0000, 8'h11, 8'h0, 3'h2, 2'h1, 3'h0});
      idle();
      chk("hold", {violFlag, violWrite, violId, violAddr}, 42'h2_5AA000_1234);
      clr();
      rg(4'd0, 32'h0, 32'hFFFF_F000, 20'h00005);
      rg(4'd3, 32'h1000_0000, 32'h100F_F000, 20'hFF12F);
      rg(4'd9, 32'h1008_0000, 32'h1008_5000, 20'hF0309);
      rg(4'd15, 32'h0, 32'hFFFF_F000, 20'h0000C);
      burst(150);
      cfg(axrf_pkg::OFS_CTRL, 32'hF, 1'b1);
      cfg(axrf_pkg::OFS_POISON, 32'hDEC0_0000, 1'b1);
      cfg(12'h108, 32'h4, 1'b1);
      rg(4'd15, 32'h1008_7000, 32'h1008_7000, 20'h00009);
      burst(150);
      repeat (20) @(posedge sys_clk);
      clr();
      req(1'b0, '{32'h1000_0040, 8'h12, 8'h0, 3'h2, 2'h1, 3'h2});
      idle();
      chk("sec", {violFlag, violSecurity, violWrite, violIrq, violId, violAddr}, 44'hD_121000_0040);
      cfg(axrf_pkg::OFS_CTRL, 32'h0, 1'b0);
      cfg(axrf_pkg::OFS_LOCK, 32'h1, 1'b1);
      cfg(12'h138, 32'h0000C, 1'b1);
      cfg(axrf_pkg::OFS_CTRL, 32'h0, 1'b1);
      @(posedge sys_clk);
      chk("lock", cfgLocked, 1'b1);
      burst(100);
      repeat (30) @(posedge sys_clk);
      end_sim();
   end
endmodule
`default_nettype wire
